/* rtl/tpes_pkg.sv */
// constants, register map and state codes of the enable switch evaluator
package tpes_pkg;

	// apb register byte offsets
	localparam logic [7:0] TPES_OFF_CTRL = 8'h00;
	localparam logic [7:0] TPES_OFF_STATUS = 8'h04;
	localparam logic [7:0] TPES_OFF_DIAG = 8'h08;

	// control register fields and reset values
	localparam int TPES_CTRL_ACTIVATE_BIT = 0;
	localparam int TPES_CTRL_RESET_BIT = 1;
	localparam logic TPES_CTRL_ACTIVATE_RST = 1'b0;
	localparam logic TPES_CTRL_RESET_RST = 1'b0;

	// status register field positions
	localparam int TPES_ST_READY_BIT = 0;
	localparam int TPES_ST_GUARD_BIT = 1;
	localparam int TPES_ST_PROT_BIT = 2;
	localparam int TPES_ST_RSTNEED_BIT = 3;
	localparam int TPES_ST_ERROR_BIT = 4;
	localparam int TPES_ST_POS_LSB = 8;
	localparam int TPES_ST_STATE_LSB = 12;

	// diagnostic words
	localparam logic [15:0] TPES_DIAG_IDLE = 16'h0000;
	localparam logic [15:0] TPES_DIAG_BASIC = 16'h8002;
	localparam logic [15:0] TPES_DIAG_SAFE = 16'h8004;
	localparam logic [15:0] TPES_DIAG_POS1 = 16'h8802;
	localparam logic [15:0] TPES_DIAG_POS3 = 16'h8804;
	localparam logic [15:0] TPES_DIAG_POS2 = 16'h8000;
	localparam logic [15:0] TPES_DIAG_C001 = 16'hC001;
	localparam logic [15:0] TPES_DIAG_C011 = 16'hC011;
	localparam logic [15:0] TPES_DIAG_C010 = 16'hC010;
	localparam logic [15:0] TPES_DIAG_C020 = 16'hC020;
	localparam logic [15:0] TPES_DIAG_C030 = 16'hC030;
	localparam logic [15:0] TPES_DIAG_C040 = 16'hC040;

	// decoded switch position
	typedef enum logic [1:0] {
		TPES_POS_ONE = 2'b00,
		TPES_POS_TWO = 2'b01,
		TPES_POS_THREE = 2'b10,
		TPES_POS_BAD = 2'b11
	} tpes_pos_t;

	// evaluator states
	typedef enum logic [3:0] {
		TPES_S_IDLE = 4'b0000,
		TPES_S_BASIC = 4'b0001,
		TPES_S_SAFE = 4'b0010,
		TPES_S_POS1 = 4'b0011,
		TPES_S_POS2 = 4'b0100,
		TPES_S_POS3 = 4'b0101,
		TPES_S_C001 = 4'b0110,
		TPES_S_C011 = 4'b0111,
		TPES_S_C010 = 4'b1000,
		TPES_S_C020 = 4'b1001,
		TPES_S_C030 = 4'b1010,
		TPES_S_C040 = 4'b1011
	} tpes_state_t;

endpackage

/* rtl/tpes_enable_switch.sv */
// three-position enabling switch evaluator with apb control and status
//
// Notes on behaviour
// - switching direction into position 2 is taken from the contact sequence.
// - guard suspension only after a move from position 1 to position 2.
// - no other direction or position ever raises guard suspension.
// - activate low forces idle from any state, above every other transition.
// - static reset or invalid switch position or sequence enters an error state.
// - guard suspension is low in every error state while it lasts.
// - a reset error is left on reset low or on safe mode low.
// - after an error the switch must be back in position 1 first.
// - without automatic reset, leaving an error needs a rising reset edge.
// - static reset in C020 gives C001; errors show ready and error high.
// - second static reset detection gives C011 with reset request low.
// - switch not in position 1 when safe mode arrives gives C010.
// - position 1 after C010 gives C020, reset request is inverse reset.
// - position 2 from 3 gives C030; leaving it gives C040 with reset request.
// - inactive is idle 0000; basic mode 8002; safe mode 8004 with ready.
// - safe mode position 1 gives 8802, position 3 gives 8804, protection on.
// - valid move into position 2 gives 8000, guard on, protection off.
`timescale 1ns/1ps
module tpes_enable_switch
	import tpes_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// switch contacts, asynchronous pins
	input wire logic contact_channel_a_i,
	input wire logic contact_channel_b_i,
	// mode inputs, asynchronous pins
	input wire logic safe_mode_confirm_i,
	input wire logic auto_reset_permit_i,
	// evaluator outputs
	output logic ready_o,
	output logic guard_suspension_out_o,
	output logic protection_request_o,
	output logic reset_needed_o,
	output logic error_o,
	output logic [15:0] diagnostic_word_o
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [3:0] sync_1;
	logic [3:0] sync_2;
	logic ctrl_activate;
	logic ctrl_reset;
	logic reset_prev;
	tpes_pos_t pos;
	tpes_pos_t next_pos;
	logic via_three;
	logic next_via_three;
	tpes_state_t state;
	tpes_state_t next_state;
	logic [15:0] next_diag;
	wire chan_a = sync_2[3];
	wire chan_b = sync_2[2];
	wire safe_ok = sync_2[1];
	wire auto_ok = sync_2[0];
	wire reset_rise = ctrl_reset & ~reset_prev;
	wire reset_static = ctrl_reset & ~reset_prev ? 1'b0 : ctrl_reset;
	wire at_one = (pos == TPES_POS_ONE);
	wire release_ok = reset_rise | auto_ok;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------

	// two stages on every pin; only the second stage is read
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			sync_1 <= 4'h0;
			sync_2 <= 4'h0;
		end
		else
		begin
			sync_1 <= {contact_channel_a_i, contact_channel_b_i,
				safe_mode_confirm_i, auto_reset_permit_i};
			sync_2 <= sync_1;
		end
	end

	// ------------------------------------------------------------
	// switch position decoder
	// ------------------------------------------------------------

	// open after a press from position 1 is the over-pressed position;
	// open after a press from position 3 is the release back to 1
	always_comb
	begin
		next_pos = pos;
		next_via_three = via_three;
		if (chan_a != chan_b)
			next_pos = TPES_POS_BAD;
		else if (chan_a)
		begin
			next_pos = TPES_POS_TWO;
			if (pos == TPES_POS_THREE)
				next_via_three = 1'b1;
			else if (pos != TPES_POS_TWO)
				next_via_three = 1'b0;
		end
		else if (pos == TPES_POS_TWO)
			next_pos = via_three ? TPES_POS_ONE : TPES_POS_THREE;
		else if (pos == TPES_POS_BAD)
			next_pos = TPES_POS_ONE;
	end

	// remember direction of entry into position 2
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			pos <= TPES_POS_ONE;
			via_three <= 1'b0;
		end
		else
		begin
			pos <= next_pos;
			via_three <= next_via_three;
		end
	end

	// ------------------------------------------------------------
	// evaluator state machine
	// ------------------------------------------------------------

	always_comb
	begin
		next_state = state;
		if (!ctrl_activate)
			next_state = TPES_S_IDLE;
		else
		begin
			case (state)
				TPES_S_IDLE:
					next_state = TPES_S_BASIC;
				TPES_S_BASIC:
					if (safe_ok)
						next_state = TPES_S_SAFE;
				TPES_S_SAFE:
					if (!safe_ok)
						next_state = TPES_S_BASIC;
					else if (at_one)
						next_state = TPES_S_POS1;
					// not in position 1 on safe mode entry
					else
						next_state = TPES_S_C010;
				TPES_S_POS1:
					if (!safe_ok)
						next_state = TPES_S_BASIC;
					// only position 1 to 2 reaches guard on
					else if (pos == TPES_POS_TWO)
						next_state = TPES_S_POS2;
					else if (!at_one)
						next_state = TPES_S_C010;
				TPES_S_POS2:
					if (!safe_ok)
						next_state = TPES_S_BASIC;
					else if (pos == TPES_POS_THREE)
						next_state = TPES_S_POS3;
					else if (at_one)
						next_state = TPES_S_POS1;
					else if (pos == TPES_POS_BAD)
						next_state = TPES_S_C010;
				TPES_S_POS3:
					if (!safe_ok)
						next_state = TPES_S_BASIC;
					// 3 to 2 never enables, it is an error
					else if (pos == TPES_POS_TWO)
						next_state = TPES_S_C030;
					else if (pos == TPES_POS_BAD)
						next_state = TPES_S_C010;
				TPES_S_C010:
					// back in position 1 after C010
					if (at_one)
						next_state = TPES_S_C020;
				TPES_S_C020:
					if (reset_static)
						next_state = TPES_S_C001;
					// position 1 plus edge or auto
					else if (release_ok && at_one)
						next_state = TPES_S_POS1;
				TPES_S_C001:
					// reset error left on reset or safe low
					if (!safe_ok)
						next_state = TPES_S_BASIC;
					else if (!ctrl_reset)
						next_state = TPES_S_C020;
				TPES_S_C030:
					if (pos != TPES_POS_TWO)
						next_state = TPES_S_C040;
				TPES_S_C040:
					if (reset_static)
						next_state = TPES_S_C011;
					// position 1 plus edge or auto
					else if (release_ok && at_one)
						next_state = TPES_S_POS1;
				TPES_S_C011:
					// reset error left on reset or safe low
					if (!safe_ok)
						next_state = TPES_S_BASIC;
					else if (!ctrl_reset)
						next_state = TPES_S_C040;
				default:
					next_state = TPES_S_IDLE;
			endcase
		end
	end

	// diagnostic word for the state being entered
	always_comb
	begin
		case (next_state)
			TPES_S_IDLE: next_diag = TPES_DIAG_IDLE;
			TPES_S_BASIC: next_diag = TPES_DIAG_BASIC;
			TPES_S_SAFE: next_diag = TPES_DIAG_SAFE;
			TPES_S_POS1: next_diag = TPES_DIAG_POS1;
			TPES_S_POS2: next_diag = TPES_DIAG_POS2;
			TPES_S_POS3: next_diag = TPES_DIAG_POS3;
			TPES_S_C001: next_diag = TPES_DIAG_C001;
			TPES_S_C011: next_diag = TPES_DIAG_C011;
			TPES_S_C010: next_diag = TPES_DIAG_C010;
			TPES_S_C020: next_diag = TPES_DIAG_C020;
			TPES_S_C030: next_diag = TPES_DIAG_C030;
			TPES_S_C040: next_diag = TPES_DIAG_C040;
			default: next_diag = TPES_DIAG_IDLE;
		endcase
	end

	// output decode from the next state, so every output is a flop
	wire next_err = next_state[3] | (next_state == TPES_S_C001) |
		(next_state == TPES_S_C011);
	// guard only in position 2 state, never in an error state
	wire next_guard = (next_state == TPES_S_POS2);
	wire next_prot = (next_state == TPES_S_POS1) | (next_state == TPES_S_POS3);
	// reset request mirrors inverse reset in C020 and C040
	wire next_rstneed = ((next_state == TPES_S_C020) |
		(next_state == TPES_S_C040)) & ~ctrl_reset;

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			state <= TPES_S_IDLE;
			reset_prev <= 1'b0;
			ready_o <= 1'b0;
			guard_suspension_out_o <= 1'b0;
			protection_request_o <= 1'b0;
			reset_needed_o <= 1'b0;
			error_o <= 1'b0;
			diagnostic_word_o <= TPES_DIAG_IDLE;
		end
		else
		begin
			state <= next_state;
			reset_prev <= ctrl_reset;
			ready_o <= (next_state != TPES_S_IDLE);
			guard_suspension_out_o <= next_guard;
			protection_request_o <= next_prot;
			reset_needed_o <= next_rstneed;
			error_o <= next_err;
			diagnostic_word_o <= next_diag;
		end
	end

	// ------------------------------------------------------------
	// apb register slave
	// ------------------------------------------------------------

	// one wait state: pready rises in the second access cycle
	wire apb_access = psel_i & penable_i;
	wire apb_done = apb_access & pready_o;
	wire hit_ctrl = (paddr_i == TPES_OFF_CTRL);
	wire hit_status = (paddr_i == TPES_OFF_STATUS);
	wire hit_diag = (paddr_i == TPES_OFF_DIAG);
	wire hit_any = hit_ctrl | hit_status | hit_diag;
	wire [31:0] rd_ctrl = {30'h0, ctrl_reset, ctrl_activate};
	wire [31:0] rd_status = {16'h0, state, 2'b00, pos, 3'b000, error_o,
		reset_needed_o, protection_request_o, guard_suspension_out_o, ready_o};
	wire [31:0] rd_diag = {16'h0, diagnostic_word_o};
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
		hit_status ? rd_status :
		hit_diag ? rd_diag : 32'h0000_0000;

	// answer handshake and read data
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			pready_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o <= apb_access & ~pready_o;
			prdata_o <= (apb_access & ~pready_o & ~pwrite_i) ? rd_mux : 32'h0000_0000;
			pslverr_o <= apb_access & ~pready_o & ~hit_any;
		end
	end

	// control register, written only on the completing edge
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_activate <= TPES_CTRL_ACTIVATE_RST;
			ctrl_reset <= TPES_CTRL_RESET_RST;
		end
		else if (apb_done & pwrite_i & hit_ctrl)
		begin
			ctrl_activate <= pwdata_i[TPES_CTRL_ACTIVATE_BIT];
			ctrl_reset <= pwdata_i[TPES_CTRL_RESET_BIT];
		end
	end

endmodule

/* tb/tpes_chk.sv */
// concurrent checks on the evaluator outputs
`timescale 1ns/1ps
module tpes_chk
	import tpes_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// watched outputs
	input wire logic pready_o,
	input wire logic ready_o,
	input wire logic guard_suspension_out_o,
	input wire logic protection_request_o,
	input wire logic reset_needed_o,
	input wire logic error_o,
	input wire logic [15:0] diagnostic_word_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	AST_IDLE: assert property (!ready_o |-> diagnostic_word_o == TPES_DIAG_IDLE && !error_o
		&& !guard_suspension_out_o && !protection_request_o && !reset_needed_o)
		else $error("idle outputs wrong");
	AST_POS13: assert property ((diagnostic_word_o == TPES_DIAG_POS1
		|| diagnostic_word_o == TPES_DIAG_POS3) |-> protection_request_o && !guard_suspension_out_o)
		else $error("position 1 or 3 outputs wrong");
	AST_GUARD: assert property (guard_suspension_out_o |-> diagnostic_word_o == TPES_DIAG_POS2
		&& !protection_request_o && ready_o && !error_o)
		else $error("guard without position 2");
	// guard may only rise straight out of position 1
	AST_RISE: assert property ($rose(guard_suspension_out_o) |->
		$past(diagnostic_word_o) == TPES_DIAG_POS1)
		else $error("guard rose not from position 1");
	AST_ERRG: assert property (error_o |-> !guard_suspension_out_o && ready_o)
		else $error("error with guard or not ready");
	AST_C001: assert property (diagnostic_word_o == TPES_DIAG_C001 |-> error_o && !reset_needed_o)
		else $error("c001 outputs wrong");
	AST_C011: assert property (diagnostic_word_o == TPES_DIAG_C011 |-> error_o && !reset_needed_o)
		else $error("c011 outputs wrong");
	AST_C030: assert property (diagnostic_word_o == TPES_DIAG_C030 |-> error_o && !reset_needed_o)
		else $error("c030 outputs wrong");
	AST_RDY: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	// the safe mode pass state shows only ready
	AST_SAFE: assert property (diagnostic_word_o == TPES_DIAG_SAFE |-> ready_o && !error_o
		&& !guard_suspension_out_o && !protection_request_o && !reset_needed_o)
		else $error("safe mode outputs wrong");
	// a reset request belongs only to the two operation errors that wait for reset
	AST_RNEED: assert property (reset_needed_o |-> error_o
		&& (diagnostic_word_o == TPES_DIAG_C020 || diagnostic_word_o == TPES_DIAG_C040))
		else $error("reset request outside c020 or c040");
endmodule

bind tpes_enable_switch tpes_chk u_chk (
	.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i),
	.pready_o(pready_o),
	.ready_o(ready_o),
	.guard_suspension_out_o(guard_suspension_out_o),
	.protection_request_o(protection_request_o),
	.reset_needed_o(reset_needed_o),
	.error_o(error_o),
	.diagnostic_word_o(diagnostic_word_o)
);

/* tb/tpes_switch_model.sv */
// three-position enabling switch with two contact channels
`timescale 1ns/1ps
module tpes_switch_model
(
	// wanted lever state: 0 open, 1 pressed, 2 channels disagree
	input wire logic [1:0] pos_i,
	// contact channels, high = closed
	output logic ch_a_o,
	output logic ch_b_o
);
	assign ch_a_o = (pos_i == 2'd1) || (pos_i == 2'd2);
	// second pair on channel b; both pairs move together except in state 2, where only channel a closes
	assign ch_b_o = (pos_i == 2'd1);
endmodule

/* tb/three_position_enable_switch_eval_tb_top.sv */
// self-checking bench of the enable switch evaluator
`timescale 1ns/1ps
module three_position_enable_switch_eval_tb_top
	import tpes_pkg::*;
;
	logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic pready, pslverr, e, ch_a, ch_b, safe = 0, auto_rst = 0;
	logic ready, guard, prot, rneed, err;
	logic [15:0] diag;
	logic [1:0] pos = 0;
	int miscompares = 0, num_checks = 0;

	tpes_switch_model u_sw (.pos_i(pos), .ch_a_o(ch_a), .ch_b_o(ch_b));
	tpes_enable_switch dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.contact_channel_a_i(ch_a), .contact_channel_b_i(ch_b),
		.safe_mode_confirm_i(safe), .auto_reset_permit_i(auto_rst), .ready_o(ready),
		.guard_suspension_out_o(guard), .protection_request_o(prot),
		.reset_needed_o(rneed), .error_o(err), .diagnostic_word_o(diag));

	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end

	// apb transfer, held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// no cycle count assumed; only the watchdog ends a hung wait
		do
		begin
			@(posedge ref_clk);
		end
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge, so a following call never reassigns psel in this step
		@(posedge ref_clk);
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// pins need 2 sync flops plus decode and state edges
	task outs(input logic [15:0] d, input logic [4:0] f);
		repeat (8) @(posedge ref_clk);
		chk({diag, 11'h000, ready, guard, prot, rneed, err}, {d, 11'h000, f});
	endtask

	task print_verdict;
		if (miscompares == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// watchdog, the sequence needs well under 2000 cycles
	initial
	begin
		#200000;
		miscompares++;
		print_verdict;
	end

	initial
	begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		apb(1'b0, TPES_OFF_DIAG, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk({r[30:0], e}, 32'h0000_0001);
		outs(TPES_DIAG_IDLE, 5'b00000);
		apb(1'b1, TPES_OFF_CTRL, 32'h0000_0001);
		outs(TPES_DIAG_BASIC, 5'b10000);
		safe <= 1'b1; // confirmation driven high
		outs(TPES_DIAG_POS1, 5'b10100);
		pos <= 2'd1;
		outs(TPES_DIAG_POS2, 5'b11000);
		pos <= 2'd0;
		outs(TPES_DIAG_POS3, 5'b10100);
		pos <= 2'd1;
		outs(TPES_DIAG_C030, 5'b10001);
		pos <= 2'd0;
		outs(TPES_DIAG_C040, 5'b10011);
		apb(1'b1, TPES_OFF_CTRL, 32'h0000_0003);
		outs(TPES_DIAG_POS1, 5'b10100);
		apb(1'b1, TPES_OFF_CTRL, 32'h0000_0001);
		safe <= 1'b0;
		outs(TPES_DIAG_BASIC, 5'b10000);
		pos <= 2'd2;
		safe <= 1'b1;
		outs(TPES_DIAG_C010, 5'b10001);
		apb(1'b1, TPES_OFF_CTRL, 32'h0000_0003);
		pos <= 2'd0;
		outs(TPES_DIAG_C001, 5'b10001);
		apb(1'b1, TPES_OFF_CTRL, 32'h0000_0001);
		outs(TPES_DIAG_C020, 5'b10011);
		auto_rst <= 1'b1; // restart judged harmless here
		outs(TPES_DIAG_POS1, 5'b10100);
		pos <= 2'd1;
		outs(TPES_DIAG_POS2, 5'b11000);
		apb(1'b1, TPES_OFF_CTRL, 32'h0000_0002);
		outs(TPES_DIAG_IDLE, 5'b00000);
		print_verdict;
	end
endmodule
